// >>> core/pxc_channel.sv
// Channel end: reset, alignment, rate change and receive status
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Host drives reset request low, high after
// [R2] Host holds alignment start four cycles
// [R3] Host waits for alignment done rise
// [R4] Host ties reserved inputs to zero
// [R5] Reset status high while in reset
// [R6] Channel offers shared PLL powerdown, reset
// [R7] Rate idle low during rate change
// [R8] Alignment done high after alignment finishes
// [R9] Entering third gen high while moving there
// [R10] Third gen ready high at Gen3 rate
// [R11] Status codes 000 to 011 defined
// [R12] Status codes 100 to 111 defined
// [R13] Host drives freq-lock from PLL locks
// [R14] Express mode only when enable set
// [R15] Gen1/2 select: 00 channel, 11 quad one
// [R16] Gen3 select set to 11
// [R17] Gen4 select set to 10
// [R18] Datapath chosen by line rate
// [R19] Supply termination during unknown detection
// [R20] Programmable termination after detection
// [R21] Rising-edge detection keeps programmable mode
// [R22] Gen3 buffer settings left untouched
// [R23] Asynchronous inputs synchronised by two stages
module pxc_channel (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    pxc_if.dev              lnk,
    input  wire logic       ev_skp_add,
    input  wire logic       ev_skp_del,
    input  wire logic       ev_rx_det,
    input  wire logic       ev_dec_err,
    input  wire logic       ev_eb_ovf,
    input  wire logic       ev_eb_unf,
    input  wire logic       ev_disp_err,
    output logic            path_gen3_sel,
    output logic [1:0]      active_pll_sel,
    output logic            active_pll_locked
);
    // ==========================================================
    // Input synchronisers
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic       rst_idle_s;
    logic       align_start_s;
    logic       gen3_req_s;
    logic [1:0] lock_s;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 5'h01;
            sync2_r <= 5'h01;
        end else begin
            sync1_r <= {lnk.quad_pll_one_freq_lock_in,     // see [R23]
                        lnk.channel_pll_freq_lock_in,
                        lnk.gen3_request, lnk.tx_align_start,
                        lnk.reset_idle_request};
            sync2_r <= sync1_r;
        end
    end
    assign rst_idle_s    = sync2_r[0];
    assign align_start_s = sync2_r[1];
    assign gen3_req_s    = sync2_r[2];
    assign lock_s        = sync2_r[4:3];

    // ==========================================================
    // Reset and alignment sequencer
    pxc_pkg::pxc_dev_state_t st_r;
    logic [3:0] cnt_r;
    logic       align_seen_r;
    logic       align_done_r;
    logic       express_en;

    assign express_en = lnk.pcs_express_mode_enable;      // see [R14]

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r         <= pxc_pkg::DS_RESET;
            cnt_r        <= 4'h0;
            align_seen_r <= 1'b0;
            align_done_r <= 1'b0;
        end else begin
            case (st_r)
                pxc_pkg::DS_IDLE: begin
                    if (express_en && !rst_idle_s) begin
                        st_r         <= pxc_pkg::DS_RESET;
                        cnt_r        <= 4'h0;
                        align_done_r <= 1'b0;
                    end
                end
                pxc_pkg::DS_RESET: begin
                    if (cnt_r != pxc_pkg::RESET_WORK_CYC)
                        cnt_r <= cnt_r + 4'h1;
                    if (align_start_s)
                        align_seen_r <= 1'b1;
                    if (align_seen_r && !align_start_s) begin
                        st_r  <= pxc_pkg::DS_ALIGN;
                        cnt_r <= 4'h0;
                    end
                    if (!express_en)
                        st_r <= pxc_pkg::DS_IDLE;
                end
                pxc_pkg::DS_ALIGN: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == pxc_pkg::ALIGN_WORK_CYC) begin
                        align_done_r <= 1'b1;              // see [R8]
                        align_seen_r <= 1'b0;
                        st_r         <= pxc_pkg::DS_RUN;
                    end
                end
                pxc_pkg::DS_RUN: begin
                    if (rst_idle_s || !express_en)
                        st_r <= pxc_pkg::DS_IDLE;
                end
                default: st_r <= pxc_pkg::DS_IDLE;
            endcase
        end
    end

    // Reset status tracks sequencer in reset or alignment
    logic phy_rst_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            phy_rst_r <= 1'b1;
        else
            phy_rst_r <= (st_r == pxc_pkg::DS_RESET) ||
                         (st_r == pxc_pkg::DS_ALIGN);     // see [R5]
    end

    // ==========================================================
    // Rate change to third generation
    logic       gen3_r;
    logic       entering_r;
    logic [3:0] rate_cnt_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gen3_r     <= 1'b0;
            entering_r <= 1'b0;
            rate_cnt_r <= 4'h0;
        end else if (!express_en || st_r != pxc_pkg::DS_IDLE) begin
            gen3_r     <= 1'b0;
            entering_r <= 1'b0;
            rate_cnt_r <= 4'h0;
        end else if (entering_r) begin
            rate_cnt_r <= rate_cnt_r + 4'h1;
            if (rate_cnt_r == pxc_pkg::RATE_WORK_CYC) begin
                entering_r <= 1'b0;
                gen3_r     <= 1'b1;                      // see [R10]
            end
        end else if (gen3_req_s != gen3_r) begin
            if (gen3_req_s) begin
                entering_r <= 1'b1;                      // see [R9]
                rate_cnt_r <= 4'h0;
            end else begin
                gen3_r <= 1'b0;
            end
        end
    end

    // Shared PLL controls: powered down outside express mode
    logic qpd_r;
    logic qrst_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            qpd_r  <= 1'b1;
            qrst_r <= 1'b1;
        end else begin
            qpd_r  <= !express_en;                       // see [R6]
            qrst_r <= !express_en || st_r == pxc_pkg::DS_RESET ||
                      (entering_r && rate_cnt_r == 4'h0);
        end
    end

    // ==========================================================
    // Receive status encoder, highest code wins
    logic [2:0] rxs_nxt;
    logic [2:0] rxs_r;
    always_comb begin
        rxs_nxt = pxc_pkg::RXS_OK;                        // see [R11]
        if (ev_disp_err)     rxs_nxt = pxc_pkg::RXS_DISP_ERR; // see [R12]
        else if (ev_eb_unf)  rxs_nxt = pxc_pkg::RXS_EB_UNF;
        else if (ev_eb_ovf)  rxs_nxt = pxc_pkg::RXS_EB_OVF;
        else if (ev_dec_err) rxs_nxt = pxc_pkg::RXS_DEC_ERR;
        else if (ev_rx_det)  rxs_nxt = pxc_pkg::RXS_RX_DET;
        else if (ev_skp_del) rxs_nxt = pxc_pkg::RXS_SKP_DEL;
        else if (ev_skp_add) rxs_nxt = pxc_pkg::RXS_SKP_ADD;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            rxs_r <= pxc_pkg::RXS_OK;
        else
            rxs_r <= (express_en && !gen3_r) ? rxs_nxt : pxc_pkg::RXS_OK;
    end

    // ==========================================================
    // PLL and datapath selection
    logic [1:0] pll_sel_r;
    logic       path_r;
    logic       pll_lock_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pll_sel_r  <= pxc_pkg::PLL_SEL_CHANNEL;
            path_r     <= 1'b0;
            pll_lock_r <= 1'b0;
        end else begin
            pll_sel_r  <= gen3_r ? lnk.pll_select_gen_three
                                 : lnk.pll_select_gen_one_two; // see [R15]
            path_r     <= gen3_r;                          // see [R18]
            pll_lock_r <= (pll_sel_r == pxc_pkg::PLL_SEL_CHANNEL)
                          ? lock_s[0] : lock_s[1];
        end
    end

    assign lnk.tx_align_done            = align_done_r;
    assign lnk.phy_reset_status         = phy_rst_r;
    assign lnk.shared_pll_powerdown_out = qpd_r;
    assign lnk.shared_pll_reset_out     = qrst_r;
    assign lnk.rate_change_idle         = !entering_r;       // see [R7]
    assign lnk.entering_third_gen       = entering_r;
    assign lnk.third_gen_ready          = gen3_r;
    assign lnk.user_rate_start_reserved = 1'b0;
    assign lnk.receive_status_code      = rxs_r;
    assign path_gen3_sel                = path_r;
    assign active_pll_sel               = pll_sel_r;
    assign active_pll_locked            = pll_lock_r;
endmodule

// >>> pkg/pxc_pkg.sv
// Shared constants and types for the express-mode channel control block
package pxc_pkg;
    // ==========================================================
    // Receive status codes
    localparam logic [2:0] RXS_OK        = 3'h0;
    localparam logic [2:0] RXS_SKP_ADD   = 3'h1;
    localparam logic [2:0] RXS_SKP_DEL   = 3'h2;
    localparam logic [2:0] RXS_RX_DET    = 3'h3;
    localparam logic [2:0] RXS_DEC_ERR   = 3'h4;
    localparam logic [2:0] RXS_EB_OVF    = 3'h5;
    localparam logic [2:0] RXS_EB_UNF    = 3'h6;
    localparam logic [2:0] RXS_DISP_ERR  = 3'h7;
    // ==========================================================
    // PLL select encodings
    localparam logic [1:0] PLL_SEL_CHANNEL  = 2'h0;
    localparam logic [1:0] PLL_SEL_QUAD_ONE = 2'h3;
    localparam logic [1:0] PLL_SEL_QUAD_ZERO = 2'h2;
    // Termination modes
    localparam logic [1:0] TERM_SUPPLY      = 2'h0;
    localparam logic [1:0] TERM_PROGRAMMABLE = 2'h3;
    // ==========================================================
    // Timing counts in clk_sys cycles
    localparam int          ALIGN_START_MIN  = 4;
    localparam logic [3:0]  ALIGN_START_CYC  = 4'(ALIGN_START_MIN);
    localparam logic [3:0]  ALIGN_WORK_CYC   = 4'h8;
    localparam logic [3:0]  RESET_WORK_CYC   = 4'h6;
    localparam logic [3:0]  RATE_WORK_CYC    = 4'h8;
    // ==========================================================
    // Host register map, byte offsets
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CFG    = 4'h8;
    localparam logic [3:0] REG_RXSTAT = 4'hc;
    // CTRL bits
    localparam int CTRL_RESET_GO  = 0;
    localparam int CTRL_GEN3_REQ  = 1;
    localparam int CTRL_DET_START = 2;
    localparam int CTRL_DET_DONE  = 3;
    localparam int CTRL_RISE_DET  = 4;
    // CFG bits
    localparam int CFG_PCIE_EN    = 0;
    localparam int CFG_SEL12_LO   = 1;
    localparam int CFG_PLLUSE     = 3;
    // STATUS bits
    localparam int ST_RESET_BUSY  = 0;
    localparam int ST_ALIGN_DONE  = 1;
    localparam int ST_RATE_IDLE   = 2;
    localparam int ST_GEN3_RDY    = 3;
    localparam int ST_ENTER_GEN3  = 4;
    localparam int ST_PHY_RST     = 5;
    localparam logic [7:0] CFG_RESET = 8'h0f;

    typedef enum logic [2:0] {
        HS_IDLE  = 3'h0,
        HS_REQ   = 3'h1,
        HS_START = 3'h3,
        HS_WAIT  = 3'h2,
        HS_DONE  = 3'h6
    } pxc_host_state_t;

    typedef enum logic [1:0] {
        DS_IDLE  = 2'h0,
        DS_RESET = 2'h1,
        DS_ALIGN = 2'h3,
        DS_RUN   = 2'h2
    } pxc_dev_state_t;
endpackage

// >>> pkg/pxc_if.sv
// Interface joining the controller and the channel
`timescale 1ns/1ps
interface pxc_if;
    logic       reset_idle_request;
    logic       tx_align_start;
    logic       tx_align_done;
    logic       eq_adapt_done_reserved;
    logic       user_rate_done_reserved;
    logic       phy_reset_status;
    logic       shared_pll_powerdown_out;
    logic       shared_pll_reset_out;
    logic       rate_change_idle;
    logic       entering_third_gen;
    logic       third_gen_ready;
    logic       user_rate_start_reserved;
    logic [2:0] receive_status_code;
    logic       channel_pll_freq_lock_in;
    logic       quad_pll_zero_freq_lock_in;
    logic       quad_pll_one_freq_lock_in;
    logic       gen3_request;
    logic       pcs_express_mode_enable;
    logic [1:0] pll_select_gen_one_two;
    logic [1:0] pll_select_gen_three;
    logic [1:0] plus_pll_select_gen_four;
    logic [1:0] rx_termination_mode;

    modport dev (
        input  reset_idle_request, tx_align_start, eq_adapt_done_reserved,
               user_rate_done_reserved, channel_pll_freq_lock_in,
               quad_pll_zero_freq_lock_in, quad_pll_one_freq_lock_in,
               gen3_request, pcs_express_mode_enable,
               pll_select_gen_one_two, pll_select_gen_three,
               plus_pll_select_gen_four, rx_termination_mode,
        output tx_align_done, phy_reset_status, shared_pll_powerdown_out,
               shared_pll_reset_out, rate_change_idle, entering_third_gen,
               third_gen_ready, user_rate_start_reserved,
               receive_status_code
    );
    modport host (
        output reset_idle_request, tx_align_start, eq_adapt_done_reserved,
               user_rate_done_reserved, channel_pll_freq_lock_in,
               quad_pll_zero_freq_lock_in, quad_pll_one_freq_lock_in,
               gen3_request, pcs_express_mode_enable,
               pll_select_gen_one_two, pll_select_gen_three,
               plus_pll_select_gen_four, rx_termination_mode,
        input  tx_align_done, phy_reset_status, shared_pll_powerdown_out,
               shared_pll_reset_out, rate_change_idle, entering_third_gen,
               third_gen_ready, user_rate_start_reserved,
               receive_status_code
    );
endinterface

// >>> core/pxc_host.sv
// Controller end: register port, reset sequence, termination switch
`timescale 1ns/1ps
module pxc_host (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    pxc_if.host              lnk,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic [31:0]      rdata,
    input  wire logic        channel_pll_locked,
    input  wire logic        quad_pll_zero_locked,
    input  wire logic        quad_pll_one_locked
);
    // ==========================================================
    // Registers
    logic [7:0] cfg_r;
    logic       gen3_req_r;
    logic       rise_det_r;
    logic       go_r;
    logic       det_start_r;
    logic       det_done_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r      <= pxc_pkg::CFG_RESET;
            gen3_req_r <= 1'b0;
            rise_det_r <= 1'b0;
            go_r       <= 1'b0;
            det_start_r <= 1'b0;
            det_done_r <= 1'b0;
        end else begin
            go_r        <= 1'b0;
            det_start_r <= 1'b0;
            det_done_r  <= 1'b0;
            if (wr_stb && addr == pxc_pkg::REG_CFG)
                cfg_r <= wdata[7:0];
            if (wr_stb && addr == pxc_pkg::REG_CTRL) begin
                go_r        <= wdata[pxc_pkg::CTRL_RESET_GO];
                gen3_req_r  <= wdata[pxc_pkg::CTRL_GEN3_REQ];
                det_start_r <= wdata[pxc_pkg::CTRL_DET_START];
                det_done_r  <= wdata[pxc_pkg::CTRL_DET_DONE];
                rise_det_r  <= wdata[pxc_pkg::CTRL_RISE_DET];
            end
        end
    end

    // ==========================================================
    // Reset and alignment sequence
    pxc_pkg::pxc_host_state_t hs_r;
    logic [3:0] hcnt_r;
    logic       done_q_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hs_r     <= pxc_pkg::HS_IDLE;
            hcnt_r   <= 4'h0;
            done_q_r <= 1'b0;
        end else begin
            done_q_r <= lnk.tx_align_done;
            case (hs_r)
                pxc_pkg::HS_IDLE:
                    if (go_r) hs_r <= pxc_pkg::HS_REQ;
                pxc_pkg::HS_REQ: begin
                    hs_r   <= pxc_pkg::HS_START;
                    hcnt_r <= 4'h0;
                end
                pxc_pkg::HS_START: begin
                    hcnt_r <= hcnt_r + 4'h1;
                    if (hcnt_r == pxc_pkg::ALIGN_START_CYC - 4'h1)
                        hs_r <= pxc_pkg::HS_WAIT;          // see [R2]
                end
                pxc_pkg::HS_WAIT:
                    if (lnk.tx_align_done && !done_q_r)
                        hs_r <= pxc_pkg::HS_DONE;          // see [R3]
                pxc_pkg::HS_DONE:
                    hs_r <= pxc_pkg::HS_IDLE;
                default: hs_r <= pxc_pkg::HS_IDLE;
            endcase
        end
    end

    // Termination mode switch around receiver detection
    logic [1:0] term_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            term_r <= pxc_pkg::TERM_PROGRAMMABLE;
        else if (rise_det_r)
            term_r <= pxc_pkg::TERM_PROGRAMMABLE;          // see [R21]
        else if (det_start_r)
            term_r <= pxc_pkg::TERM_SUPPLY;                // see [R19]
        else if (det_done_r)
            term_r <= pxc_pkg::TERM_PROGRAMMABLE;          // see [R20]
    end

    // ==========================================================
    // Drives toward the channel
    logic use_plls;
    assign use_plls = cfg_r[pxc_pkg::CFG_PCIE_EN] & cfg_r[pxc_pkg::CFG_PLLUSE];
    assign lnk.reset_idle_request = (hs_r == pxc_pkg::HS_IDLE) ||
                                    (hs_r == pxc_pkg::HS_DONE); // see [R1]
    assign lnk.tx_align_start     = (hs_r == pxc_pkg::HS_START);
    assign lnk.eq_adapt_done_reserved  = 1'b0;              // see [R4]
    assign lnk.user_rate_done_reserved = 1'b0;
    assign lnk.channel_pll_freq_lock_in   = use_plls & channel_pll_locked;
    assign lnk.quad_pll_zero_freq_lock_in =
        use_plls & quad_pll_zero_locked;                    // see [R13]
    assign lnk.quad_pll_one_freq_lock_in  = use_plls & quad_pll_one_locked;
    assign lnk.gen3_request            = gen3_req_r;
    assign lnk.pcs_express_mode_enable = cfg_r[pxc_pkg::CFG_PCIE_EN];
    assign lnk.pll_select_gen_one_two  =
        cfg_r[pxc_pkg::CFG_SEL12_LO +: 2];
    assign lnk.pll_select_gen_three = pxc_pkg::PLL_SEL_QUAD_ONE; // see [R16]
    assign lnk.plus_pll_select_gen_four =
        pxc_pkg::PLL_SEL_QUAD_ZERO; // see [R17]
    assign lnk.rx_termination_mode      = term_r;

    // ==========================================================
    // Read port, data one cycle after strobe
    logic [31:0] rd_nxt;
    always_comb begin
        rd_nxt = 32'h0;
        case (addr)
            pxc_pkg::REG_CTRL:
                rd_nxt = {27'h0, rise_det_r, 2'h0, gen3_req_r, 1'b0};
            pxc_pkg::REG_STATUS:
                rd_nxt = {26'h0, lnk.phy_reset_status,
                          lnk.entering_third_gen, lnk.third_gen_ready,
                          lnk.rate_change_idle, lnk.tx_align_done,
                          hs_r != pxc_pkg::HS_IDLE};
            pxc_pkg::REG_CFG:    rd_nxt = {24'h0, cfg_r};
            pxc_pkg::REG_RXSTAT: rd_nxt = {29'h0, lnk.receive_status_code};
            default:             rd_nxt = 32'h0;
        endcase
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            rdata <= 32'h0;
        else
            rdata <= rd_stb ? rd_nxt : 32'h0;
    end
endmodule

// >>> verif/pxc_properties.sv
// Concurrent checks on the controller to channel link
`timescale 1ns/1ps
module pxc_properties (
    input wire logic       clk_sys,
    input wire logic       rst_n,
    input wire logic       reset_idle_request,
    input wire logic       tx_align_start,
    input wire logic       tx_align_done,
    input wire logic       eq_adapt_done_reserved,
    input wire logic       user_rate_done_reserved,
    input wire logic       phy_reset_status,
    input wire logic       rate_change_idle,
    input wire logic       entering_third_gen,
    input wire logic       third_gen_ready,
    input wire logic       gen3_request,
    input wire logic [2:0] receive_status_code,
    input wire logic [1:0] pll_select_gen_three,
    input wire logic [1:0] plus_pll_select_gen_four
);
    // ==========================================================
    // Link properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_start_len;
        $rose(tx_align_start) |-> tx_align_start [*4];
    endproperty
    a_start_len: assert property (p_start_len)
        else $error("align start too short");
    property p_req_release;
        $rose(reset_idle_request) |-> tx_align_done;
    endproperty
    a_req_release: assert property (p_req_release)
        else $error("request released early");
    property p_reserved;
        !eq_adapt_done_reserved && !user_rate_done_reserved;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved input high");
    property p_rst_status;
        $fell(reset_idle_request) |-> ##[1:4] phy_reset_status;
    endproperty
    a_rst_status: assert property (p_rst_status)
        else $error("reset status not raised");
    property p_align_done;
        $fell(tx_align_start) |-> !tx_align_done ##[4:24] $rose(tx_align_done);
    endproperty
    a_align_done: assert property (p_align_done)
        else $error("alignment done missing");
    property p_gen3_enter;
        $rose(gen3_request) |-> ##[1:4] (entering_third_gen && !rate_change_idle);
    endproperty
    a_gen3_enter: assert property (p_gen3_enter)
        else $error("rate change not signalled");
    property p_gen3_ready;
        $rose(gen3_request) |-> ##[8:16] third_gen_ready;
    endproperty
    a_gen3_ready: assert property (p_gen3_ready)
        else $error("third gen ready late");
    property p_gen3_quiet;
        third_gen_ready |-> receive_status_code == 3'h0;
    endproperty
    a_gen3_quiet: assert property (p_gen3_quiet)
        else $error("status code at third gen");
    property p_sel_fixed;
        pll_select_gen_three == pxc_pkg::PLL_SEL_QUAD_ONE
            && plus_pll_select_gen_four == pxc_pkg::PLL_SEL_QUAD_ZERO;
    endproperty
    a_sel_fixed: assert property (p_sel_fixed)
        else $error("fixed pll select wrong");
endmodule

// >>> verif/tb.sv
// Self-checking bench for the controller and channel pair
`timescale 1ns/1ps
module tb;
    typedef struct {int due; int kind; logic [31:0] exp;} pxc_note_t;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic [6:0]  ev = 7'h0;
    logic [6:0]  v7;
    logic [2:0]  lk = 3'h0;
    logic [31:0] rdata;
    logic        path_gen3_sel;
    logic [1:0]  active_pll_sel;
    logic        active_pll_locked;
    int          cyc = 0;
    int          n_errors = 0;
    int          checks = 0;
    pxc_note_t   q[$];

    always #12.5 clk_sys = ~clk_sys;
    pxc_if lnk ();
    pxc_host pxc_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .lnk(lnk),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .channel_pll_locked(lk[2]),
        .quad_pll_zero_locked(lk[1]), .quad_pll_one_locked(lk[0]));
    pxc_channel pxc_channel_i (.clk_sys(clk_sys), .rst_n(rst_n), .lnk(lnk),
        .ev_skp_add(ev[0]), .ev_skp_del(ev[1]), .ev_rx_det(ev[2]),
        .ev_dec_err(ev[3]), .ev_eb_ovf(ev[4]), .ev_eb_unf(ev[5]),
        .ev_disp_err(ev[6]), .path_gen3_sel(path_gen3_sel),
        .active_pll_sel(active_pll_sel),
        .active_pll_locked(active_pll_locked));
    pxc_properties pxc_properties_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .reset_idle_request(lnk.reset_idle_request),
        .tx_align_start(lnk.tx_align_start),
        .tx_align_done(lnk.tx_align_done),
        .eq_adapt_done_reserved(lnk.eq_adapt_done_reserved),
        .user_rate_done_reserved(lnk.user_rate_done_reserved),
        .phy_reset_status(lnk.phy_reset_status),
        .rate_change_idle(lnk.rate_change_idle),
        .entering_third_gen(lnk.entering_third_gen),
        .third_gen_ready(lnk.third_gen_ready),
        .gen3_request(lnk.gen3_request),
        .receive_status_code(lnk.receive_status_code),
        .pll_select_gen_three(lnk.pll_select_gen_three),
        .plus_pll_select_gen_four(lnk.plus_pll_select_gen_four));

    // ==========================================================
    // Notes, bus cycles and comparison
    task automatic note(input int k, input logic [31:0] x, input int d);
        q.push_back('{cyc + d, k, x});
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr   <= a;
        wdata  <= w ? d : 32'h0;
        wr_stb <= w;
        rd_stb <= !w;
        if (!w) note(1, d, 2);
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
    endtask
    task automatic later(input int k, input logic [31:0] x);
        repeat (4) @(posedge clk_sys);
        note(k, x, 1);
    endtask
    function automatic logic [31:0] code(input logic [6:0] v);
        code = 32'h0;
        for (int b = 0; b < 7; b++) if (v[b]) code = 32'(b + 1);
    endfunction
    task automatic check(input string n, input logic [31:0] x,
                         input logic [31:0] g);
        checks++;
        if (g !== x) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic test_done;
        n_errors += q.size();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(negedge clk_sys) begin
        cyc = cyc + 1;
        while (q.size() > 0 && q[0].due == cyc) begin
            case (q[0].kind)
                0: check("rxst", q[0].exp, 32'(lnk.receive_status_code));
                1: check("rdata", q[0].exp, rdata);
                2: check("term", q[0].exp, 32'(lnk.rx_termination_mode));
                3: check("flock", q[0].exp, 32'({lnk.channel_pll_freq_lock_in,
                    lnk.quad_pll_zero_freq_lock_in, lnk.quad_pll_one_freq_lock_in}));
                default: check("path", q[0].exp, 32'({
                    lnk.shared_pll_reset_out, active_pll_sel,
                    active_pll_locked, path_gen3_sel}));
            endcase
            void'(q.pop_front());
        end
    end

    initial begin
        repeat (3000) @(posedge clk_sys);
        n_errors++;
        $display("BAD watchdog expected finish seen timeout");
        test_done;
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h714be7aa));
        lk = 3'($urandom);
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        bus(1'b0, pxc_pkg::REG_CFG, 32'(pxc_pkg::CFG_RESET));
        bus(1'b0, 4'h1, 32'h0);
        later(3, 32'(lk));
        later(4, {28'h1, 2'h3, lk[0], 1'b0});
        bus(1'b1, pxc_pkg::REG_CTRL, 32'h1);
        for (int i = 0; i < 80 && lnk.tx_align_done !== 1'b1; i++)
            @(posedge clk_sys);
        repeat (8) @(posedge clk_sys);
        bus(1'b0, pxc_pkg::REG_STATUS, 32'h6);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            v7 = (i < 8) ? 7'((1 << i) >> 1) : 7'($urandom);
            ev <= v7;
            note(0, code(v7), 2);
        end
        @(posedge clk_sys);
        ev <= 7'h0;
        bus(1'b1, pxc_pkg::REG_CTRL, 32'h4);
        later(2, 32'(pxc_pkg::TERM_SUPPLY));
        bus(1'b1, pxc_pkg::REG_CTRL, 32'h8);
        later(2, 32'(pxc_pkg::TERM_PROGRAMMABLE));
        bus(1'b1, pxc_pkg::REG_CTRL, 32'h14);
        later(2, 32'(pxc_pkg::TERM_PROGRAMMABLE));
        bus(1'b1, pxc_pkg::REG_CFG, 32'h9);
        later(4, {28'h0, 2'h0, lk[2], 1'b0});
        bus(1'b1, pxc_pkg::REG_CFG, 32'h7);
        later(3, 32'h0);
        bus(1'b1, pxc_pkg::REG_CFG, 32'hf);
        bus(1'b1, pxc_pkg::REG_CTRL, 32'h2);
        for (int i = 0; i < 40 && lnk.third_gen_ready !== 1'b1; i++)
            @(posedge clk_sys);
        bus(1'b0, pxc_pkg::REG_STATUS, 32'he);
        later(4, {28'h0, 2'h3, lk[0], 1'b1});
        @(posedge clk_sys);
        ev <= 7'h7f;
        note(0, 32'h0, 2);
        @(posedge clk_sys);
        ev <= 7'h0;
        bus(1'b1, pxc_pkg::REG_CTRL, 32'h0);
        repeat (6) @(posedge clk_sys);
        test_done;
    end
endmodule
